//--- tpqm_pkg.sv
// Package of the transmit packet queue manager: map, fields, carriers.
// Assumes a 32-bit Avalon-MM host bus and a MAC running on ref_clk.
// What this block does
// [RULE1] Allocate command tries to reserve the requested bytes of packet RAM.
// [RULE2] Successful allocation posts packet number and sets allocation flag.
// [RULE3] Host waits for allocation by polling the flag or its interrupt.
// [RULE4] Host sets packet number, pointer, then block-writes frame data.
// [RULE5] Data access hits packet and pointer location; pointer then advances.
// [RULE6] Enqueue command pushes packet number register into transmit queue.
// [RULE7] Host does nothing more for the packet until a transmit interrupt.
// [RULE8] Packets go to MAC only when enabled and, in half duplex, deferral allows.
// [RULE9] On completion the status word overwrites the packet's first word.
// [RULE10] Completed packet number moves from transmit to completion queue.
// [RULE11] Transmit interrupt is active while completion queue is not empty.
// [RULE12] Failure sets event flag, clears transmitter enable, halts sending.
// [RULE13] Failed packet number is shown at the queue ports register.
// [RULE14] Host reads status, completed number, sets packet number, reads status.
// [RULE15] Host releases successfully sent packets when automatic freeing is off.
// [RULE16] Acknowledge write removes head number from completion queue.
// [RULE17] After failure host releases, or re-enables and re-enqueues packet.
// [RULE18] With automatic freeing on, device frees packet memory on completion.
package tpqm_pkg;

  // Default sizes
  localparam int NPKT_DEF   = 4;
  localparam int WORDS_DEF  = 16;
  localparam int QDEPTH_DEF = 4;
  localparam int PNW        = 6;
  localparam int LENW       = 11;
  localparam int INTW       = 4;

  // Register byte offsets
  localparam logic [5:0] OFF_CMD    = 6'h00;
  localparam logic [5:0] OFF_ALLOC  = 6'h04;
  localparam logic [5:0] OFF_PKTNUM = 6'h08;
  localparam logic [5:0] OFF_PTR    = 6'h0C;
  localparam logic [5:0] OFF_DATA   = 6'h10;
  localparam logic [5:0] OFF_TCR    = 6'h14;
  localparam logic [5:0] OFF_ISTAT  = 6'h18;
  localparam logic [5:0] OFF_IMASK  = 6'h1C;
  localparam logic [5:0] OFF_PORTS  = 6'h20;
  localparam logic [5:0] OFF_TXACK  = 6'h24;
  localparam logic [5:0] OFF_LINK   = 6'h28;

  // Command codes in bits 2:0, byte count field position
  localparam logic [2:0] CMD_ALLOC   = 3'h1;
  localparam logic [2:0] CMD_ENQ     = 3'h2;
  localparam logic [2:0] CMD_REL     = 3'h3;
  localparam int         CMD_LEN_LSB = 16;

  // transmit_control_reg bits and reset value
  localparam int         TCR_TXEN = 0;
  localparam int         TCR_HDX  = 1;
  localparam int         TCR_AUTO = 2;
  localparam logic [2:0] TCR_RST  = 3'h0;

  // Interrupt status and mask bits
  localparam int              INT_ALLOC = 0;
  localparam int              INT_TX    = 1;
  localparam int              INT_FAIL  = 2;
  localparam int              INT_EMPTY = 3;
  localparam logic [INTW-1:0] IMASK_RST = 4'h0;

  // Flag bit in result and ports registers, failed number field
  localparam int          FLAG_BIT   = 7;
  localparam int          FAIL_LSB   = 8;
  localparam int          FAIL_FLAG  = 15;
  localparam logic [31:0] UNMAPPED   = 32'h0;

  // Avalon-MM request from the host
  typedef struct packed {
    logic [5:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } tpqm_req_t;

  // Avalon-MM answer to the host
  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } tpqm_rsp_t;

  // Word stream towards the MAC
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
    logic        last;
  } tpqm_txw_t;

endpackage : tpqm_pkg

//--- tpqm_fifo.sv
// Small queue of packet numbers held in flip-flops.
// Assumes D is a power of two; push when full and pop when empty are ignored.
`timescale 1ns/1ns
module tpqm_fifo #(
  parameter int W = 6,
  parameter int D = 4
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic                   push,
  input  wire logic [W-1:0]           din,
  input  wire logic                   pop,
  output logic      [W-1:0]           dout,
  output logic                        empty,
  output logic                        full,
  output logic      [$clog2(D+1)-1:0] count
);
  import tpqm_pkg::*;

  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D+1);

  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] rd_r;
  logic [AW-1:0] wr_r;
  logic [CW-1:0] cnt_r;
  logic          do_push;
  logic          do_pop;

  // Guarded strobes and status
  assign do_push = push && !full;
  assign do_pop  = pop && !empty;
  assign empty   = cnt_r == '0;
  assign full    = cnt_r == CW'(D);
  assign dout    = mem_r[rd_r];
  assign count   = cnt_r;

  // Pointers and fill count
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_r  <= '0;
      wr_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (do_push)
        wr_r <= wr_r + 1'b1;
      if (do_pop)
        rd_r <= rd_r + 1'b1;
      if (do_push && !do_pop)
        cnt_r <= cnt_r + 1'b1;
      else if (do_pop && !do_push)
        cnt_r <= cnt_r - 1'b1;
    end
  end

  // Storage
  always_ff @(posedge ref_clk) begin
    if (do_push)
      mem_r[wr_r] <= din;
  end

endmodule : tpqm_fifo

//--- tpqm_top.sv
// Transmit packet queue manager: bus slave, packet RAM, queues and engine.
// Assumes an Avalon-MM master and a MAC on ref_clk; defer_ok is a pin.
`timescale 1ns/1ns
module tpqm_top #(
  parameter int NPKT   = tpqm_pkg::NPKT_DEF,
  parameter int WORDS  = tpqm_pkg::WORDS_DEF,
  parameter int QDEPTH = tpqm_pkg::QDEPTH_DEF
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire tpqm_pkg::tpqm_req_t av_req,
  output tpqm_pkg::tpqm_rsp_t      av_rsp,
  output logic                     irq,
  output tpqm_pkg::tpqm_txw_t      mac_tx,
  input  wire logic                mac_ready,
  input  wire logic                mac_done,
  input  wire logic                mac_fail,
  input  wire logic [15:0]         mac_status,
  input  wire logic                defer_ok
);
  import tpqm_pkg::*;

  localparam int PW  = $clog2(WORDS);
  localparam int SW  = $clog2(NPKT);
  localparam int QCW = $clog2(QDEPTH+1);
  localparam logic [LENW-1:0] MAXLEN = LENW'(2*WORDS);

  typedef enum logic [1:0] {E_IDLE, E_SEND, E_WAIT} tpqm_eng_t;

  tpqm_eng_t        st_r;
  tpqm_txw_t        tx_r;
  logic             ack_r;
  logic [31:0]      rdata_r;
  logic [31:0]      rmux;
  logic [15:0]      mem_r [NPKT*WORDS];
  logic [LENW-1:0]  len_r [NPKT];
  logic [NPKT-1:0]  free_r;
  logic [PNW-1:0]   pkt_num_r;
  logic [PNW-1:0]   alloc_pn_r;
  logic             alloc_fail_r;
  logic [PNW-1:0]   cur_r;
  logic [PNW-1:0]   fail_pn_r;
  logic             fail_seen_r;
  logic [PW-1:0]    ptr_r;
  logic [PW-1:0]    wi_r;
  logic [PW-1:0]    last_r;
  logic [2:0]       transmit_control_reg_r;
  logic [15:0]      link_layer_status_reg_r;
  logic [INTW-1:0]  istat_r;
  logic [INTW-1:0]  imask_r;
  logic [INTW-1:0]  ilive;
  logic [INTW-1:0]  iset;
  logic             defer_m_r;
  logic             defer_s_r;

  logic             do_wr;
  logic             do_rd;
  logic [2:0]       cmd_op;
  logic [LENW-1:0]  cmd_len;
  logic             wr_cmd;
  logic             alloc_go;
  logic             alloc_ok;
  logic             enq_go;
  logic             rel_go;
  logic             ack_go;
  logic             data_acc;
  logic             rd_istat;
  logic             ff_hit;
  logic [SW-1:0]    ff_idx;
  logic [SW+PW-1:0] host_idx;
  logic [SW+PW-1:0] eng_idx;
  logic [SW+PW-1:0] eng0_idx;
  logic [SW-1:0]    cur_slot;
  logic             start_ok;
  logic             done_ok;
  logic             done_bad;

  logic [PNW-1:0]   txq_head;
  logic             txq_empty;
  logic             txq_full;
  logic [QCW-1:0]   txq_cnt;
  logic             txq_pop;
  logic [PNW-1:0]   cq_head;
  logic             cq_empty;
  logic             cq_full;
  logic [QCW-1:0]   cq_cnt;

  // Bus handshake: one wait cycle, then the access takes effect
  assign av_rsp.waitrequest = (av_req.read || av_req.write) && !ack_r;
  assign av_rsp.readdata    = rdata_r;
  assign do_wr              = av_req.write && ack_r;
  assign do_rd              = av_req.read && ack_r;

  // Command and register strobes
  assign cmd_op   = av_req.writedata[2:0];
  assign cmd_len  = av_req.writedata[CMD_LEN_LSB +: LENW];
  assign wr_cmd   = do_wr && av_req.address == OFF_CMD;
  assign alloc_go = wr_cmd && cmd_op == CMD_ALLOC;
  assign alloc_ok = alloc_go && ff_hit && cmd_len != '0
                    && cmd_len <= MAXLEN;  // see [RULE1]
  assign enq_go   = wr_cmd && cmd_op == CMD_ENQ;
  assign rel_go   = wr_cmd && cmd_op == CMD_REL;
  assign ack_go   = do_wr && av_req.address == OFF_TXACK;
  assign data_acc = (do_wr || do_rd) && av_req.address == OFF_DATA;
  assign rd_istat = do_rd && av_req.address == OFF_ISTAT;

  // Packet RAM addressing by slot and word pointer
  assign host_idx = {pkt_num_r[SW-1:0], ptr_r};  // see [RULE5]
  assign cur_slot = cur_r[SW-1:0];
  assign eng_idx  = {cur_slot, wi_r};
  assign eng0_idx = {cur_slot, PW'(0)};

  // Engine conditions
  assign start_ok = st_r == E_IDLE && !txq_empty
                    && transmit_control_reg_r[TCR_TXEN]
                    && (!transmit_control_reg_r[TCR_HDX]
                        || defer_s_r);  // see [RULE8]
  assign done_ok  = st_r == E_WAIT && mac_done && !mac_fail;
  assign done_bad = st_r == E_WAIT && mac_done && mac_fail;
  assign txq_pop  = st_r == E_WAIT && mac_done;
  assign mac_tx   = tx_r;

  // Lowest free packet slot
  always_comb begin
    ff_hit = 1'b0;
    ff_idx = '0;
    for (int i = NPKT - 1; i >= 0; i--) begin
      if (free_r[i]) begin
        ff_hit = 1'b1;
        ff_idx = SW'(i);
      end
    end
  end

  // Transmit queue of enqueued packet numbers
  tpqm_fifo #(.W(PNW), .D(QDEPTH)) u_txq (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .push    (enq_go),  // see [RULE6]
    .din     (pkt_num_r),
    .pop     (txq_pop),
    .dout    (txq_head),
    .empty   (txq_empty),
    .full    (txq_full),
    .count   (txq_cnt)
  );

  // Completion queue, popped by the acknowledge write
  tpqm_fifo #(.W(PNW), .D(QDEPTH)) u_cq (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .push    (done_ok),  // see [RULE10]
    .din     (cur_r),
    .pop     (ack_go),  // see [RULE16]
    .dout    (cq_head),
    .empty   (cq_empty),
    .full    (cq_full),
    .count   (cq_cnt)
  );

  // Bus phase and registered read data
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ack_r   <= 1'b0;
      rdata_r <= '0;
    end else begin
      ack_r <= (av_req.read || av_req.write) && !ack_r;
      if (av_req.read && !ack_r)
        rdata_r <= rmux;
    end
  end

  // Read multiplexer
  always_comb begin
    unique case (av_req.address)
      OFF_ALLOC:
        rmux = 32'({alloc_fail_r, 1'b0, alloc_pn_r});
      OFF_PKTNUM: rmux = 32'(pkt_num_r);
      OFF_PTR:    rmux = 32'(ptr_r);
      OFF_DATA:   rmux = 32'(mem_r[host_idx]);
      OFF_TCR:    rmux = 32'(transmit_control_reg_r);
      OFF_ISTAT:  rmux = 32'(ilive);
      OFF_IMASK:  rmux = 32'(imask_r);
      OFF_PORTS:
        rmux = 32'({fail_seen_r, 1'b0, fail_pn_r,
                    cq_empty, 1'b0, cq_head});  // see [RULE13]
      OFF_LINK:   rmux = 32'(link_layer_status_reg_r);
      default:    rmux = UNMAPPED;
    endcase
  end

  // Pin synchroniser for the deferral permit
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      defer_m_r <= 1'b0;
      defer_s_r <= 1'b0;
    end else begin
      defer_m_r <= defer_ok;
      defer_s_r <= defer_m_r;
    end
  end

  // Packet number, pointer and mask registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pkt_num_r <= '0;
      ptr_r     <= '0;
      imask_r   <= IMASK_RST;
    end else begin
      if (do_wr && av_req.address == OFF_PKTNUM)
        pkt_num_r <= av_req.writedata[PNW-1:0];
      if (do_wr && av_req.address == OFF_PTR)
        ptr_r <= av_req.writedata[PW-1:0];
      else if (data_acc)
        ptr_r <= ptr_r + 1'b1;  // see [RULE5]
      if (do_wr && av_req.address == OFF_IMASK)
        imask_r <= av_req.writedata[INTW-1:0];
    end
  end

  // Control register; a failure clears the enable over a host write
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      transmit_control_reg_r <= TCR_RST;
    end else begin
      if (do_wr && av_req.address == OFF_TCR)
        transmit_control_reg_r <= av_req.writedata[2:0];
      if (done_bad)
        transmit_control_reg_r[TCR_TXEN] <= 1'b0;  // see [RULE12]
    end
  end

  // Slot ownership and allocation result
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      free_r       <= '1;
      alloc_pn_r   <= '0;
      alloc_fail_r <= 1'b0;
    end else begin
      if (alloc_go) begin
        alloc_fail_r <= !alloc_ok;  // see [RULE1]
        if (alloc_ok) begin
          alloc_pn_r     <= PNW'(ff_idx);  // see [RULE2]
          free_r[ff_idx] <= 1'b0;
        end
      end
      if (rel_go)
        free_r[pkt_num_r[SW-1:0]] <= 1'b1;
      if (done_ok && transmit_control_reg_r[TCR_AUTO])
        free_r[cur_slot] <= 1'b1;  // see [RULE18]
    end
  end

  // Byte count kept per slot for the engine
  always_ff @(posedge ref_clk) begin
    if (alloc_ok)
      len_r[ff_idx] <= cmd_len;
  end

  // Packet RAM: host data writes and status write-back
  always_ff @(posedge ref_clk) begin
    if (data_acc && do_wr)
      mem_r[host_idx] <= av_req.writedata[15:0];  // see [RULE5]
    if (txq_pop)
      mem_r[eng0_idx] <= mac_status;  // see [RULE9]
  end

  // Last completion status and failure capture
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      link_layer_status_reg_r <= '0;
      fail_pn_r               <= '0;
      fail_seen_r             <= 1'b0;
    end else begin
      if (txq_pop)
        link_layer_status_reg_r <= mac_status;
      if (enq_go || rel_go)
        fail_seen_r <= 1'b0;
      if (done_bad) begin
        fail_pn_r   <= cur_r;  // see [RULE13]
        fail_seen_r <= 1'b1;
      end
    end
  end

  // Interrupt events; the transmit bit follows the completion queue
  always_comb begin
    iset            = '0;
    iset[INT_ALLOC] = alloc_ok;  // see [RULE2]
    iset[INT_FAIL]  = done_bad;  // see [RULE12]
    iset[INT_EMPTY] = done_ok && txq_cnt == QCW'(1);
    ilive           = istat_r;
    ilive[INT_TX]   = !cq_empty;  // see [RULE11]
  end

  // Sticky status, cleared by a read of what was shown; set wins
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      istat_r <= '0;
    else if (rd_istat)
      istat_r <= (istat_r & ~rdata_r[INTW-1:0]) | iset;
    else
      istat_r <= istat_r | iset;
  end

  assign irq = |(ilive & imask_r);

  // Transmit engine: fetch word, hand to MAC, wait for the outcome
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r   <= E_IDLE;
      wi_r   <= '0;
      last_r <= '0;
      cur_r  <= '0;
      tx_r   <= '0;
    end else begin
      unique case (st_r)
        E_IDLE: begin
          if (start_ok) begin  // see [RULE8]
            cur_r  <= txq_head;
            wi_r   <= '0;
            last_r <= PW'((len_r[txq_head[SW-1:0]] - 1'b1) >> 1);
            st_r   <= E_SEND;
          end
        end
        E_SEND: begin
          if (!tx_r.valid) begin
            tx_r.valid <= 1'b1;
            tx_r.data  <= mem_r[eng_idx];
            tx_r.last  <= wi_r == last_r;
          end else if (mac_ready) begin
            tx_r.valid <= 1'b0;
            if (tx_r.last)
              st_r <= E_WAIT;
            else
              wi_r <= wi_r + 1'b1;
          end
        end
        E_WAIT: begin
          if (mac_done)
            st_r <= E_IDLE;
        end
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_done_ok;
    done_ok;
  endsequence

  sequence s_done_bad;
    done_bad;
  endsequence

  AST_ALLOC_BIG: assert property ( // see [RULE1]
    alloc_go && cmd_len > MAXLEN |=> alloc_fail_r && $stable(free_r))
    else $error("Oversized allocation was not refused");

  AST_ALLOC_DONE: assert property ( // see [RULE2]
    alloc_ok |=> istat_r[INT_ALLOC] && !alloc_fail_r
      && alloc_pn_r == PNW'($past(ff_idx)))
    else $error("Allocation result or flag missing");

  AST_PTR_STEP: assert property ( // see [RULE5]
    data_acc |=> ptr_r == PW'($past(ptr_r) + 1'b1))
    else $error("Pointer did not advance after data access");

  AST_ENQ_PUSH: assert property ( // see [RULE6]
    enq_go && !txq_full && !txq_pop
      |=> txq_cnt == QCW'($past(txq_cnt) + 1'b1))
    else $error("Enqueue did not reach the transmit queue");

  AST_TXEN_GATE: assert property ( // see [RULE8]
    st_r == E_IDLE && !transmit_control_reg_r[TCR_TXEN]
      |=> st_r == E_IDLE)
    else $error("Transmission started while disabled");

  AST_STATUS_WB: assert property ( // see [RULE9]
    txq_pop |=> mem_r[$past(eng0_idx)] == $past(mac_status))
    else $error("Status word not written to first word");

  AST_CQ_MOVE: assert property ( // see [RULE10]
    s_done_ok ##0 (!cq_full && !ack_go && !enq_go)
      |=> cq_cnt == QCW'($past(cq_cnt) + 1'b1)
        && txq_cnt == QCW'($past(txq_cnt) - 1'b1))
    else $error("Completed number not moved to completion queue");

  AST_TX_IRQ: assert property ( // see [RULE11]
    !cq_empty && imask_r[INT_TX] |-> irq)
    else $error("Transmit interrupt missing with completions queued");

  AST_FAIL_HALT: assert property ( // see [RULE12]
    s_done_bad |=> !transmit_control_reg_r[TCR_TXEN]
      && istat_r[INT_FAIL] && st_r == E_IDLE ##1 st_r == E_IDLE)
    else $error("Failure did not halt the transmitter");

  AST_FAIL_PORTS: assert property ( // see [RULE13]
    s_done_bad |=> fail_seen_r && fail_pn_r == $past(cur_r))
    else $error("Failed packet number not presented");

  AST_ACK_POP: assert property ( // see [RULE16]
    ack_go && !cq_empty && !done_ok
      |=> cq_cnt == QCW'($past(cq_cnt) - 1'b1))
    else $error("Acknowledge did not pop the completion queue");

  AST_AUTO_FREE: assert property ( // see [RULE18]
    s_done_ok ##0 transmit_control_reg_r[TCR_AUTO]
      |=> free_r[$past(cur_slot)])
    else $error("Automatic freeing did not release the slot");

endmodule : tpqm_top

//--- tpqm_mac_model.sv
// MAC-side model: takes frame words and reports the result of each packet.
// Assumes the word carrier of tpqm_pkg and the design's ref_clk.
`timescale 1ns/1ns
module tpqm_mac_model (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire tpqm_pkg::tpqm_txw_t mac_tx,
  input  wire logic               slow,
  input  wire logic               fail_req,
  input  wire logic [15:0]        status_val,
  output logic                    mac_ready,
  output logic                    mac_done,
  output logic                    mac_fail,
  output logic      [15:0]        mac_status
);
  import tpqm_pkg::*;
  logic [15:0] words[$];
  logic [2:0]  gap_r;
  logic        pend_r;
  logic        tog_r;

  // Collects words; after the last one waits, longer when slow
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
      gap_r  <= 3'h0;
      tog_r  <= 1'b0;
    end else begin
      tog_r <= ~tog_r;
      if (mac_tx.valid && mac_ready) begin
        words.push_back(mac_tx.data);
        if (mac_tx.last) begin
          pend_r <= 1'b1;
          gap_r  <= slow ? 3'h6 : 3'h1;
        end
      end else if (pend_r && gap_r != 3'h0) begin
        gap_r <= gap_r - 3'h1;
      end else if (pend_r) begin
        pend_r <= 1'b0;
      end
    end
  end

  // Stalls every other cycle when slow; status changes outside the pulse
  assign mac_ready  = !slow || tog_r;
  assign mac_done   = pend_r && gap_r == 3'h0;
  assign mac_fail   = mac_done && fail_req;
  assign mac_status = mac_done ? status_val : {15'h0, tog_r} ^ ~status_val;
endmodule : tpqm_mac_model

//--- tpqm_tb_top.sv
// Self-checking bench of the transmit packet queue manager.
// Assumes tpqm_top with NPKT=4, WORDS=16 and the MAC model beside it.
`timescale 1ns/1ns
module tpqm_tb_top;
  import tpqm_pkg::*;
  localparam int NP = 4;
  logic        ref_clk, rst_n, defer_ok, slow, fail_req, irq;
  logic        mac_ready, mac_done, mac_fail;
  logic [15:0] mac_status, status_val;
  logic [31:0] r, q;
  logic [5:0]  p;
  logic [5:0]  ps[NP];
  tpqm_req_t   av_req;
  tpqm_rsp_t   av_rsp;
  tpqm_txw_t   mac_tx;
  int          fails, num_checks;

  tpqm_top #(.NPKT(NP), .WORDS(16), .QDEPTH(4)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .av_req(av_req), .av_rsp(av_rsp),
    .irq(irq), .mac_tx(mac_tx), .mac_ready(mac_ready),
    .mac_done(mac_done), .mac_fail(mac_fail), .mac_status(mac_status),
    .defer_ok(defer_ok));
  tpqm_mac_model i_mac (
    .ref_clk(ref_clk), .rst_n(rst_n), .mac_tx(mac_tx), .slow(slow),
    .fail_req(fail_req), .status_val(status_val), .mac_ready(mac_ready),
    .mac_done(mac_done), .mac_fail(mac_fail), .mac_status(mac_status));

  // Clock of 10 ns
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One Avalon cycle: hold until waitrequest low, then release
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] o);
    int n;
    n = 0;
    av_req <= '{a, ~w, w, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (av_rsp.waitrequest !== 1'b0 && n < 100);
    o = av_rsp.readdata;
    if (n >= 100) fails++;
    av_req <= '0;
    @(posedge ref_clk);
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] o;
    bus(1'b1, a, d, o);
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [31:0] o);
    bus(1'b0, a, 32'h0, o);
  endtask : rd

  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] o;
    rd(a, o);
    chk(o, e);
  endtask : rdc

  function automatic logic [15:0] pat(input logic [5:0] k, input int i);
    return {8'hA5, k[3:0], i[3:0]};
  endfunction : pat

  task automatic alloc(input logic [10:0] nb, output logic [31:0] o);
    wr(OFF_CMD, {5'h0, nb, 13'h0, CMD_ALLOC});
    rd(OFF_ALLOC, o);
  endtask : alloc

  task automatic load(input logic [5:0] k, input int n);
    wr(OFF_PKTNUM, {26'h0, k});
    wr(OFF_PTR, 32'h0);
    for (int i = 0; i < n; i++) wr(OFF_DATA, {16'h0, pat(k, i)});
  endtask : load

  task automatic cmd(input logic [2:0] op, input logic [5:0] k);
    wr(OFF_PKTNUM, {26'h0, k});
    wr(OFF_CMD, {29'h0, op});
  endtask : cmd

  task automatic wait_done;
    int n;
    n = 0;
    while (mac_done !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 400) fails++;
    repeat (2) @(posedge ref_clk);
  endtask : wait_done

  // Counts cycles with a word offered to the MAC over n cycles and expects none
  task automatic idle(input int n);
    int v;
    v = 0;
    repeat (n) begin
      @(posedge ref_clk);
      if (mac_tx.valid !== 1'b0) v++;
    end
    chk(32'(v), 32'h0);
  endtask : idle

  task automatic chkw(input logic [5:0] k, input int n);
    chk(32'(i_mac.words.size()), 32'(n));
    for (int i = 0; i < n; i++)
      chk({16'h0, i_mac.words[i]}, {16'h0, pat(k, i)});
    i_mac.words.delete();
  endtask : chkw

  task automatic t_reset;
    rdc(OFF_TCR, 32'h0);
    rdc(OFF_IMASK, 32'h0);
    rdc(OFF_ISTAT, 32'h0);
    rd(OFF_PORTS, r);
    chk(r & 32'h8080, 32'h80);
    rdc(6'h2C, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_alloc;
    alloc(11'd0, r);
    chk(r & 32'h80, 32'h80);
    alloc(11'd33, r);
    chk(r & 32'h80, 32'h80);
    alloc(11'd32, r);
    chk(r & 32'hBC, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_IMASK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd(OFF_ISTAT, q);
    chk(q & 32'h1, 32'h1);
    chk({31'h0, irq}, 32'h0);
    cmd(CMD_REL, r[5:0]);
    $display("test alloc done");
  endtask : t_alloc

  task automatic t_send;
    status_val <= 16'h3C5A;
    alloc(11'd7, r);
    p = r[5:0];
    load(p, 4);
    rdc(OFF_PTR, 32'h4);
    wr(OFF_PTR, 32'h1);
    rdc(OFF_DATA, {16'h0, pat(p, 1)});
    rdc(OFF_DATA, {16'h0, pat(p, 2)});
    cmd(CMD_ENQ, p);
    wr(OFF_IMASK, 32'h2);
    idle(20);
    wr(OFF_TCR, 32'h3);
    idle(20);
    defer_ok <= 1'b1;
    wait_done;
    chkw(p, 4);
    chk({31'h0, irq}, 32'h1);
    // Alloc done, completion pending and queue drained all shown
    rd(OFF_ISTAT, q);
    chk(q & 32'hF, 32'hB);
    rd(OFF_PORTS, q);
    chk(q & 32'hBF, {26'h0, p});
    wr(OFF_PKTNUM, {26'h0, p});
    wr(OFF_PTR, 32'h0);
    rdc(OFF_DATA, 32'h3C5A);
    wr(OFF_TXACK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rd(OFF_PORTS, q);
    chk(q & 32'h80, 32'h80);
    cmd(CMD_REL, p);
    $display("test send done");
  endtask : t_send

  task automatic t_fail;
    slow <= 1'b1;
    fail_req <= 1'b1;
    status_val <= 16'h8421;
    wr(OFF_TCR, 32'h1);
    wr(OFF_IMASK, 32'h4);
    alloc(11'd4, r);
    p = r[5:0];
    load(p, 2);
    cmd(CMD_ENQ, p);
    wait_done;
    chkw(p, 2);
    rdc(OFF_TCR, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rd(OFF_PORTS, q);
    chk(q & 32'hBF00, {16'h0, 1'b1, 1'b0, p, 8'h0});
    rd(OFF_ISTAT, q);
    chk(q & 32'h4, 32'h4);
    chk({31'h0, irq}, 32'h0);
    rdc(OFF_LINK, 32'h8421);
    // Failed frame got its status in word 0; restore the frame word
    wr(OFF_PTR, 32'h0);
    rdc(OFF_DATA, 32'h8421);
    load(p, 1);
    fail_req <= 1'b0;
    wr(OFF_TCR, 32'h1);
    cmd(CMD_ENQ, p);
    rd(OFF_PORTS, q);
    chk(q & 32'h8000, 32'h0);
    wait_done;
    chkw(p, 2);
    rd(OFF_PORTS, q);
    chk(q & 32'hBF, {26'h0, p});
    wr(OFF_TXACK, 32'h0);
    cmd(CMD_REL, p);
    slow <= 1'b0;
    $display("test fail done");
  endtask : t_fail

  task automatic t_auto;
    wr(OFF_TCR, 32'h5);
    alloc(11'd2, r);
    p = r[5:0];
    load(p, 1);
    cmd(CMD_ENQ, p);
    wait_done;
    chkw(p, 1);
    wr(OFF_TXACK, 32'h0);
    for (int i = 0; i < NP; i++) begin
      alloc(11'd2, r);
      chk(r & 32'h80, 32'h0);
      ps[i] = r[5:0];
    end
    alloc(11'd2, r);
    chk(r & 32'h80, 32'h80);
    for (int i = 0; i < NP; i++) cmd(CMD_REL, ps[i]);
    $display("test auto done");
  endtask : t_auto

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    close_out;
  end

  // Main sequence
  initial begin
    fails = 0;
    num_checks = 0;
    rst_n = 1'b0;
    av_req = '0;
    defer_ok = 1'b0;
    slow = 1'b0;
    fail_req = 1'b0;
    status_val = 16'h0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset;
    t_alloc;
    t_send;
    t_fail;
    t_auto;
    close_out;
  end
endmodule : tpqm_tb_top
